// [pkg/otg_pkg.sv]
package otg_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned T_B_IDLE_MS = 5;
  localparam int unsigned T_A_SE0_RESP_MS = 3;
  localparam int unsigned T_SETTLE_US = 30;
  localparam int unsigned T_B_RESET_MS = 1;
  localparam int unsigned T_A_IDLE_MS = 3;
  localparam int unsigned T_BUS_RESET_MS = 10;
  localparam int unsigned CYC_B_IDLE = T_B_IDLE_MS * (CLK_HZ / 1000);
  localparam int unsigned CYC_A_SE0_RESP = T_A_SE0_RESP_MS * (CLK_HZ / 1000);
  localparam int unsigned CYC_SETTLE = T_SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CYC_B_RESET = T_B_RESET_MS * (CLK_HZ / 1000);
  localparam int unsigned CYC_A_IDLE = T_A_IDLE_MS * (CLK_HZ / 1000);
  localparam int unsigned CYC_BUS_RESET = T_BUS_RESET_MS * (CLK_HZ / 1000);
  localparam int unsigned CYC_J_WAIT = CYC_A_SE0_RESP + CYC_SETTLE;
  localparam int unsigned TIMER_W = 19;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [5:0] IRQ_MASK_RST = 6'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [6:0] PIN_RST = 7'h13;
  localparam int unsigned PIN_W = 7;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_A_HOST = 4'h1,
    ST_A_SUSPEND = 4'h2,
    ST_A_PERIPH = 4'h3,
    ST_A_WAIT_CONN = 4'h4,
    ST_A_BUS_RESET = 4'h5,
    ST_B_PERIPH = 4'h6,
    ST_B_WAIT_J = 4'h7,
    ST_B_BUS_RESET = 4'h8,
    ST_B_HOST = 4'h9,
    ST_B_DONE = 4'ha
  } role_state_t;

  typedef struct packed {
    logic power_save;
    logic early_pullup;
    logic host_done;
    logic end_session;
    logic hnp_request;
    logic hnp_enable;
    logic vbus_on;
  } ctrl_t;

  typedef struct packed {
    logic woke;
    logic to_periph;
    logic to_host;
    logic vsess_rise;
    logic id_change;
    logic sess_req;
  } event_t;

  typedef struct packed {
    logic sess_req;
    logic vsess;
    logic id;
    logic dp;
    logic dm;
    logic cs_n;
    logic rd_n;
  } pins_t;

endpackage

// [core/otg_pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module otg_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Bit clears as soon as stages two and three differ and sets only once both are high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= RST_VAL;
    end else begin
      q <= (q & ~(s2_reg ^ s3_reg)) | (s2_reg & ~(s2_reg ^ s3_reg));
    end
  end

endmodule

`default_nettype wire

// [core/otg_interval_timer.sv]
`timescale 1ns/1ps
`default_nettype none

module otg_interval_timer #(
  parameter int W = 19
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic [W-1:0] limit,
  output logic [W-1:0] count,
  output logic reached
);

  // Counts up from a clear and saturates at the limit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (count < limit) begin
      count <= count + 1'b1;
    end
  end

  assign reached = (count >= limit);

endmodule

`default_nettype wire

// [core/otg_role_swap_and_wake.sv]
// Summary of operation
// - An A-device hands over the host role only after enabling negotiation on the B-device and suspending the bus.
// - A B-device with negotiation enabled that sees the bus idle over 5 ms drops its DP pull-up.
// - A suspended A-device that sees SE0 takes it as a host request and raises its pull-up within 3 ms.
// - The B-device waits 30 us after dropping its pull-up, then takes the host role on seeing J.
// - The new B host drives bus reset within 1 ms of the A-device pull-up appearing.
// - A finished B host stops traffic and raises its pull-up, early if asked, at latest once A drops its own.
// - An A peripheral seeing over 3 ms of idle drops its pull-up, or ends the session by removing VBUS.
// - The A-device waits 30 us after dropping its pull-up, then on J resumes host and drives bus reset.
// - Power saving is entered only outside a session and stops both controllers, PLL, oscillator and pump.
// - The slow keep-alive clock keeps running in power saving so session requests are still seen.
// - A session request, an ID change or session-valid detection restarts PLL and oscillator.
// - Each of these three wake sources only wakes the device when its own enable bit is set.
// - Chip select and read strobe asserted together wake the device.
// - ID low selects the A-device role, ID high the B-device role.
// - A B-device acts as peripheral and raises its DP pull-up once VBUS is session valid.
//
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module otg_role_swap_and_wake #(
  parameter int unsigned IDLE_B_CYC = otg_pkg::CYC_B_IDLE,
  parameter int unsigned IDLE_A_CYC = otg_pkg::CYC_A_IDLE,
  parameter int unsigned J_WAIT_CYC = otg_pkg::CYC_J_WAIT,
  parameter int unsigned BUS_RESET_CYC = otg_pkg::CYC_BUS_RESET
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic ID,
  input wire logic B_SESSION_VALID_LEVEL,
  input wire logic SESSION_REQUEST,
  input wire logic DP_RX,
  input wire logic DM_RX,
  input wire logic CHIP_SELECT_N,
  input wire logic READ_STROBE_N,
  output logic DP_PULLUP_EN,
  output logic SE0_DRIVE,
  output logic VBUS_DRIVE,
  output logic HOST_ROLE,
  output logic PLL_EN,
  output logic OSC_EN,
  output logic PUMP_SUSPEND,
  output logic CTRL_SUSPEND,
  output logic IRQ
);

  localparam int TW = otg_pkg::TIMER_W;
  localparam logic [TW-1:0] SETTLE_CYC = TW'(otg_pkg::CYC_SETTLE);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  otg_pkg::pins_t pins_raw;
  otg_pkg::pins_t pins;

  assign pins_raw = '{sess_req: SESSION_REQUEST, vsess: B_SESSION_VALID_LEVEL, id: ID,
                      dp: DP_RX, dm: DM_RX, cs_n: CHIP_SELECT_N, rd_n: READ_STROBE_N};

  otg_pin_sync #(
    .W(otg_pkg::PIN_W),
    .RST_VAL(otg_pkg::PIN_RST)
  ) u_sync (
    .clk(CLK),
    .rst(RST),
    .d(pins_raw),
    .q(pins)
  );

  logic se0;
  logic jstate;
  logic line_change;
  logic [1:0] line_prev_reg;
  otg_pkg::pins_t pins_prev_reg;

  assign se0 = !pins.dp && !pins.dm;
  assign jstate = pins.dp && !pins.dm;
  assign line_change = {pins.dp, pins.dm} != line_prev_reg;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      line_prev_reg <= 2'h0;
      pins_prev_reg <= otg_pkg::PIN_RST;
    end else begin
      line_prev_reg <= {pins.dp, pins.dm};
      pins_prev_reg <= pins;
    end
  end

  // ----------------------------------------
  // Registers and bus slave
  // ----------------------------------------
  otg_pkg::ctrl_t ctrl_reg;
  otg_pkg::role_state_t state_reg;
  otg_pkg::role_state_t state_next;
  logic [5:0] irq_status_reg;
  logic [5:0] irq_mask_reg;
  logic asleep_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic addr_phase;
  logic bus_read;
  logic wr_ctrl;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic [31:0] read_value;
  otg_pkg::event_t ev;
  logic wake;
  logic leave_a_host;
  logic leave_b_host;

  assign addr_phase = HSEL && HREADY && (HTRANS == otg_pkg::HTRANS_NONSEQ || HTRANS == 2'h3);
  assign bus_read = addr_phase && !HWRITE;
  assign wr_ctrl = wr_pend_reg && wr_addr_reg == otg_pkg::ADDR_CTRL;
  assign wr_irq_status = wr_pend_reg && wr_addr_reg == otg_pkg::ADDR_IRQ_STATUS;
  assign wr_irq_mask = wr_pend_reg && wr_addr_reg == otg_pkg::ADDR_IRQ_MASK;

  always_comb begin
    if (HADDR[7:0] == otg_pkg::ADDR_CTRL) begin
      read_value = {25'h0, ctrl_reg};
    end else if (HADDR[7:0] == otg_pkg::ADDR_STATUS) begin
      read_value = {22'h0, state_reg, asleep_reg, pins.dp, pins.dm, pins.id, pins.vsess, HOST_ROLE};
    end else if (HADDR[7:0] == otg_pkg::ADDR_IRQ_STATUS) begin
      read_value = {26'h0, irq_status_reg};
    end else if (HADDR[7:0] == otg_pkg::ADDR_IRQ_MASK) begin
      read_value = {26'h0, irq_mask_reg};
    end else begin
      read_value = 32'h0000_0000;
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      HREADYOUT <= 1'b0;
      HRESP <= 1'b0;
      HRDATA <= 32'h0000_0000;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      wr_pend_reg <= addr_phase && HWRITE && HADDR[1:0] == 2'h0;
      if (addr_phase) begin
        wr_addr_reg <= HADDR[7:0];
      end
      if (bus_read) begin
        HRDATA <= read_value;
      end
    end
  end

  // Software bits; the handshake bits drop as their state is left
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_reg <= otg_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= HWDATA[6:0];
    end else begin
      if (leave_a_host || leave_b_host) begin
        ctrl_reg.hnp_request <= 1'b0;
      end
      if (leave_b_host) begin
        ctrl_reg.host_done <= 1'b0;
      end
      if (wake) begin
        ctrl_reg.power_save <= 1'b0;
      end
      // Ending the session also drops the supply request
      if (state_reg == otg_pkg::ST_A_PERIPH && state_next == otg_pkg::ST_IDLE) begin
        ctrl_reg.vbus_on <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      irq_mask_reg <= otg_pkg::IRQ_MASK_RST;
    end else if (wr_irq_mask) begin
      irq_mask_reg <= HWDATA[5:0];
    end
  end

  // Events win over a simultaneous write-one clear
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      irq_status_reg <= 6'h00;
    end else begin
      irq_status_reg <= (irq_status_reg & ~(wr_irq_status ? HWDATA[5:0] : 6'h00)) | ev;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------
  // Timers
  // ----------------------------------------
  logic [TW-1:0] idle_limit;
  logic [TW-1:0] idle_count;
  logic idle_reached;
  logic [TW-1:0] st_limit;
  logic [TW-1:0] st_count;
  logic st_reached;

  assign idle_limit = pins.id ? TW'(IDLE_B_CYC) : TW'(IDLE_A_CYC);

  always_comb begin
    if (state_reg == otg_pkg::ST_B_WAIT_J) begin
      st_limit = TW'(J_WAIT_CYC);
    end else if (state_reg == otg_pkg::ST_A_BUS_RESET || state_reg == otg_pkg::ST_B_BUS_RESET) begin
      st_limit = TW'(BUS_RESET_CYC);
    end else begin
      st_limit = SETTLE_CYC;
    end
  end

  // Both timers run on the clock that stays up through suspend
  otg_interval_timer #(
    .W(TW)
  ) u_idle_timer (
    .clk(CLK),
    .rst(RST),
    .clear(line_change),
    .limit(idle_limit),
    .count(idle_count),
    .reached(idle_reached)
  );

  otg_interval_timer #(
    .W(TW)
  ) u_state_timer (
    .clk(CLK),
    .rst(RST),
    .clear(state_next != state_reg),
    .limit(st_limit),
    .count(st_count),
    .reached(st_reached)
  );

  // ----------------------------------------
  // Role state machine
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      otg_pkg::ST_IDLE: begin
        if (!asleep_reg && !pins.id && ctrl_reg.vbus_on) begin
          state_next = otg_pkg::ST_A_HOST;
        end else if (!asleep_reg && pins.id && pins.vsess) begin
          state_next = otg_pkg::ST_B_PERIPH;
        end
      end
      otg_pkg::ST_A_HOST: begin
        if (ctrl_reg.hnp_enable && ctrl_reg.hnp_request) begin
          state_next = otg_pkg::ST_A_SUSPEND;
        end
      end
      otg_pkg::ST_A_SUSPEND: begin
        if (se0) begin
          state_next = otg_pkg::ST_A_PERIPH;
        end
      end
      otg_pkg::ST_A_PERIPH: begin
        if (idle_reached && ctrl_reg.end_session) begin
          state_next = otg_pkg::ST_IDLE;
        end else if (idle_reached) begin
          state_next = otg_pkg::ST_A_WAIT_CONN;
        end
      end
      otg_pkg::ST_A_WAIT_CONN: begin
        if (st_count >= SETTLE_CYC && jstate) begin
          state_next = otg_pkg::ST_A_BUS_RESET;
        end
      end
      otg_pkg::ST_A_BUS_RESET: begin
        if (st_reached) begin
          state_next = otg_pkg::ST_A_HOST;
        end
      end
      otg_pkg::ST_B_PERIPH: begin
        if (ctrl_reg.hnp_enable && ctrl_reg.hnp_request && idle_reached) begin
          state_next = otg_pkg::ST_B_WAIT_J;
        end
      end
      otg_pkg::ST_B_WAIT_J: begin
        if (st_count >= SETTLE_CYC && jstate) begin
          state_next = otg_pkg::ST_B_BUS_RESET;
        end else if (st_reached) begin
          state_next = otg_pkg::ST_B_PERIPH;
        end
      end
      otg_pkg::ST_B_BUS_RESET: begin
        if (st_reached) begin
          state_next = otg_pkg::ST_B_HOST;
        end
      end
      otg_pkg::ST_B_HOST: begin
        if (ctrl_reg.host_done) begin
          state_next = otg_pkg::ST_B_DONE;
        end
      end
      otg_pkg::ST_B_DONE: begin
        if (ctrl_reg.early_pullup || se0) begin
          state_next = otg_pkg::ST_B_PERIPH;
        end
      end
      default: begin
        state_next = otg_pkg::ST_IDLE;
      end
    endcase
    // Session ends on plug change, VBUS loss or VBUS switched off
    if (state_reg != otg_pkg::ST_IDLE && pins.id != pins_prev_reg.id) begin
      state_next = otg_pkg::ST_IDLE;
    end else if (pins.id && state_reg != otg_pkg::ST_IDLE && !pins.vsess) begin
      state_next = otg_pkg::ST_IDLE;
    end else if (!pins.id && state_reg != otg_pkg::ST_IDLE && !ctrl_reg.vbus_on) begin
      state_next = otg_pkg::ST_IDLE;
    end
  end

  assign leave_a_host = state_reg == otg_pkg::ST_A_HOST && state_next != otg_pkg::ST_A_HOST;
  assign leave_b_host = state_reg == otg_pkg::ST_B_HOST && state_next != otg_pkg::ST_B_HOST;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= otg_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Line outputs
  // ----------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      DP_PULLUP_EN <= 1'b0;
      SE0_DRIVE <= 1'b0;
      VBUS_DRIVE <= 1'b0;
      HOST_ROLE <= 1'b0;
    end else begin
      // Pull-up rises the cycle after SE0, far inside 3 ms
      DP_PULLUP_EN <= state_next == otg_pkg::ST_A_PERIPH || state_next == otg_pkg::ST_B_PERIPH ||
                      (state_next == otg_pkg::ST_B_DONE && ctrl_reg.early_pullup);
      // Reset follows J once the 30 us settle has passed, far inside 1 ms
      SE0_DRIVE <= state_next == otg_pkg::ST_A_BUS_RESET || state_next == otg_pkg::ST_B_BUS_RESET;
      VBUS_DRIVE <= state_next inside {otg_pkg::ST_A_HOST, otg_pkg::ST_A_SUSPEND, otg_pkg::ST_A_PERIPH,
                                       otg_pkg::ST_A_WAIT_CONN, otg_pkg::ST_A_BUS_RESET};
      HOST_ROLE <= state_next inside {otg_pkg::ST_A_HOST, otg_pkg::ST_A_SUSPEND, otg_pkg::ST_A_WAIT_CONN,
                                      otg_pkg::ST_A_BUS_RESET, otg_pkg::ST_B_BUS_RESET, otg_pkg::ST_B_HOST};
    end
  end

  // ----------------------------------------
  // Events and wake-up
  // ----------------------------------------
  logic strobe_wake;
  logic source_wake;

  always_comb begin
    ev.sess_req = pins.sess_req && !pins_prev_reg.sess_req;
    ev.id_change = pins.id != pins_prev_reg.id;
    ev.vsess_rise = pins.vsess && !pins_prev_reg.vsess;
    ev.to_host = (state_reg == otg_pkg::ST_A_BUS_RESET && state_next == otg_pkg::ST_A_HOST) ||
                 (state_reg == otg_pkg::ST_B_BUS_RESET && state_next == otg_pkg::ST_B_HOST);
    ev.to_periph = (state_reg != otg_pkg::ST_A_PERIPH && state_next == otg_pkg::ST_A_PERIPH) ||
                   (state_reg != otg_pkg::ST_B_PERIPH && state_next == otg_pkg::ST_B_PERIPH);
    ev.woke = asleep_reg && wake;
  end

  assign strobe_wake = !pins.cs_n && !pins.rd_n || bus_read;
  assign source_wake = |({ev.vsess_rise, ev.id_change, ev.sess_req} & irq_mask_reg[2:0]);
  assign wake = asleep_reg && (strobe_wake || source_wake);

  // Only the slow clock keeps running while asleep
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      asleep_reg <= 1'b0;
    end else if (wake) begin
      asleep_reg <= 1'b0;
    end else if (ctrl_reg.power_save && state_reg == otg_pkg::ST_IDLE && state_next == otg_pkg::ST_IDLE) begin
      asleep_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PLL_EN <= 1'b1;
      OSC_EN <= 1'b1;
      PUMP_SUSPEND <= 1'b0;
      CTRL_SUSPEND <= 1'b0;
    end else begin
      PLL_EN <= !(asleep_reg && !wake);
      OSC_EN <= !(asleep_reg && !wake);
      PUMP_SUSPEND <= asleep_reg && !wake;
      CTRL_SUSPEND <= asleep_reg && !wake;
    end
  end

endmodule

`default_nettype wire

// [tb/otg_role_swap_and_wake_chk.sv]
`timescale 1ns/1ps
`default_nettype none

module otg_role_swap_and_wake_chk (
  input wire logic CLK,
  input wire logic RST,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic ID,
  input wire logic B_SESSION_VALID_LEVEL,
  input wire logic CHIP_SELECT_N,
  input wire logic READ_STROBE_N,
  input wire logic DP_PULLUP_EN,
  input wire logic SE0_DRIVE,
  input wire logic VBUS_DRIVE,
  input wire logic HOST_ROLE,
  input wire logic PLL_EN,
  input wire logic OSC_EN,
  input wire logic PUMP_SUSPEND,
  input wire logic CTRL_SUSPEND
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sequence s_strobe_held;
    (!CHIP_SELECT_N && !READ_STROBE_N) [*6];
  endsequence

  a_bus_ready: assert property (!$past(RST) |-> HREADYOUT && !HRESP)
    else $error("bus not ready or error response");
  a_clocks_paired: assert property (PLL_EN == OSC_EN && PUMP_SUSPEND == CTRL_SUSPEND && CTRL_SUSPEND == !PLL_EN)
    else $error("sleep outputs disagree");
  a_sleep_idle: assert property ($rose(CTRL_SUSPEND) |-> !VBUS_DRIVE && !DP_PULLUP_EN && !HOST_ROLE)
    else $error("sleep entered during a session");
  a_strobe_wake: assert property (CTRL_SUSPEND ##0 s_strobe_held |-> ##[0:4] !CTRL_SUSPEND)
    else $error("select with read strobe did not wake");
  a_vbus_a_only: assert property (ID [*8] |=> !VBUS_DRIVE)
    else $error("supply driven with id high");
  a_b_needs_vsess: assert property ((ID && !B_SESSION_VALID_LEVEL) [*8] |=> !DP_PULLUP_EN)
    else $error("pull-up on without valid session");
  a_reset_no_pullup: assert property (SE0_DRIVE |-> !DP_PULLUP_EN)
    else $error("bus reset with pull-up on");
  a_settle_wait: assert property ($fell(DP_PULLUP_EN) |-> !SE0_DRIVE [*8])
    else $error("bus reset too soon after pull-up release");
endmodule

bind otg_role_swap_and_wake otg_role_swap_and_wake_chk otg_role_swap_and_wake_chk_i (
  .CLK(CLK), .RST(RST), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ID(ID),
  .B_SESSION_VALID_LEVEL(B_SESSION_VALID_LEVEL), .CHIP_SELECT_N(CHIP_SELECT_N),
  .READ_STROBE_N(READ_STROBE_N), .DP_PULLUP_EN(DP_PULLUP_EN), .SE0_DRIVE(SE0_DRIVE),
  .VBUS_DRIVE(VBUS_DRIVE), .HOST_ROLE(HOST_ROLE), .PLL_EN(PLL_EN), .OSC_EN(OSC_EN),
  .PUMP_SUSPEND(PUMP_SUSPEND), .CTRL_SUSPEND(CTRL_SUSPEND)
);

`default_nettype wire

// [tb/otg_peer_model.sv]
`timescale 1ns/1ps
`default_nettype none

module otg_peer_model #(
  parameter int IDLE_CYC = 60,
  parameter int RESP_CYC = 30
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic role_a,
  input wire logic hnp_en,
  input wire logic dut_pullup,
  input wire logic dut_se0,
  output logic dp,
  output logic dm
);
  logic pu_reg;
  logic [1:0] step_reg;
  logic [15:0] cnt_reg;

  // Released line falls to SE0 through the pull-downs
  assign dp = !dut_se0 && (dut_pullup || pu_reg);
  assign dm = 1'b0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pu_reg <= !role_a;
      step_reg <= 2'h0;
      cnt_reg <= 16'h0000;
    end else if (role_a) begin
      if (step_reg == 2'h0 && dut_pullup)
        step_reg <= 2'h1;
      cnt_reg <= (step_reg == 2'h1 && !dp && !dut_se0) ? cnt_reg + 16'h0001 : 16'h0000;
      if (step_reg == 2'h1 && cnt_reg == 16'(RESP_CYC)) begin
        pu_reg <= 1'b1;
        step_reg <= 2'h2;
      end
    end else begin
      cnt_reg <= (step_reg == 2'h0 && hnp_en) ? cnt_reg + 16'h0001 : 16'h0000;
      if (step_reg == 2'h0 && cnt_reg == 16'(IDLE_CYC)) begin
        pu_reg <= 1'b0;
        step_reg <= 2'h1;
      end
      if (step_reg == 2'h1 && dut_pullup)
        step_reg <= 2'h2;
      if (step_reg == 2'h2 && !dut_pullup) begin
        pu_reg <= 1'b1;
        step_reg <= 2'h3;
      end
    end
  end
endmodule

`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", nm, e, g); end end

module tb_top;
  logic CLK = 0, RST = 1, HSEL = 1, HWRITE = 0, CHIP_SELECT_N = 1, READ_STROBE_N = 1;
  logic peer_rst = 1, role_a = 1, hnp_en = 0;
  logic [2:0] src = 3'h0;
  logic [1:0] HTRANS = 2'h0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd, obs;
  logic HREADYOUT, HRESP, DP_RX, DM_RX, DP_PULLUP_EN, SE0_DRIVE, VBUS_DRIVE, HOST_ROLE;
  logic PLL_EN, OSC_EN, PUMP_SUSPEND, CTRL_SUSPEND, IRQ;
  logic [19:0] lfsr = 20'h17c70;
  logic [31:0] exp_q[$];
  string nm_q[$];
  event obs_ev;
  int err_count = 0, cmp_count = 0, n;
  wire logic [3:0] outs = {PLL_EN, HOST_ROLE, DP_PULLUP_EN, SE0_DRIVE};

  initial forever #12.5 CLK = ~CLK;

  otg_role_swap_and_wake #(.IDLE_B_CYC(50), .IDLE_A_CYC(40), .J_WAIT_CYC(1400), .BUS_RESET_CYC(20))
    otg_role_swap_and_wake_i (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ID(~src[1]), .B_SESSION_VALID_LEVEL(src[2]),
    .SESSION_REQUEST(src[0]), .DP_RX(DP_RX), .DM_RX(DM_RX), .CHIP_SELECT_N(CHIP_SELECT_N),
    .READ_STROBE_N(READ_STROBE_N), .DP_PULLUP_EN(DP_PULLUP_EN), .SE0_DRIVE(SE0_DRIVE),
    .VBUS_DRIVE(VBUS_DRIVE), .HOST_ROLE(HOST_ROLE), .PLL_EN(PLL_EN), .OSC_EN(OSC_EN),
    .PUMP_SUSPEND(PUMP_SUSPEND), .CTRL_SUSPEND(CTRL_SUSPEND), .IRQ(IRQ));

  otg_peer_model otg_peer_model_i (.clk(CLK), .rst(peer_rst), .role_a(role_a), .hnp_en(hnp_en),
    .dut_pullup(DP_PULLUP_EN), .dut_se0(SE0_DRIVE), .dp(DP_RX), .dm(DM_RX));

  function automatic logic [19:0] next_rand(input logic [19:0] s);
    return {s[18:0], s[19] ^ s[16]};
  endfunction

  task automatic report_and_stop();
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    obs = g;
    -> obs_ev;
    #1;
  endtask

  // ----------------------------------------
  // Single word transfer, zero or more waits
  // ----------------------------------------
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge CLK);
    HTRANS <= otg_pkg::HTRANS_NONSEQ;
    HWRITE <= wr;
    HADDR <= {24'h000000, a};
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask

  task automatic wait_bit(input int i, input logic v);
    n = 0;
    while (outs[i] !== v && n < 50000) begin
      @(negedge CLK);
      n++;
    end
  endtask

  task automatic idle(input int c);
    repeat (c) @(negedge CLK);
  endtask

  task automatic pulse(input int i, input int len);
    @(posedge CLK);
    src <= src ^ (3'h1 << i);
    repeat (len) @(posedge CLK);
    src <= src ^ (3'h1 << i);
    repeat (len) @(posedge CLK);
    @(negedge CLK);
  endtask

  initial begin
    string nm;
    logic [31:0] e;
    forever begin
      @(obs_ev);
      nm = nm_q.pop_front();
      e = exp_q.pop_front();
      `CHK(nm, e, obs)
    end
  end

  initial begin
    repeat (40000) @(posedge CLK);
    err_count++;
    report_and_stop();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    peer_rst <= 1'b0;
    repeat (2) @(posedge CLK);
    bus(1'b0, otg_pkg::ADDR_IRQ_MASK, 32'h0);
    check("mask reset", {26'h0, otg_pkg::IRQ_MASK_RST}, rd);
    bus(1'b0, 8'h40, 32'h0);
    check("unmapped", 32'h0, rd);
    lfsr = next_rand(lfsr);
    bus(1'b1, otg_pkg::ADDR_IRQ_MASK, {12'h000, lfsr});
    bus(1'b0, otg_pkg::ADDR_IRQ_MASK, 32'h0);
    check("mask rw", {26'h0, lfsr[5:0]}, rd);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, otg_pkg::ADDR_IRQ_MASK, 32'h0);
      bus(1'b1, otg_pkg::ADDR_IRQ_STATUS, 32'h3f);
      bus(1'b1, otg_pkg::ADDR_CTRL, 32'h40);
      idle(4);
      check("asleep", 3'b101, {CTRL_SUSPEND, PLL_EN, PUMP_SUSPEND});
      lfsr = next_rand(lfsr);
      pulse(i, 8 + lfsr[2:0]);
      check("gated", 2'b10, {CTRL_SUSPEND, IRQ});
      bus(1'b1, otg_pkg::ADDR_IRQ_MASK, 32'h1 << i);
      idle(3);
      check("irq raised", 1'b1, IRQ);
      pulse(i, 8);
      check("woken", 2'b01, {CTRL_SUSPEND, PLL_EN});
      bus(1'b0, otg_pkg::ADDR_IRQ_STATUS, 32'h0);
      check("cause", (32'h1 << i) | 32'h20, rd & ((32'h1 << i) | 32'h20));
      bus(1'b1, otg_pkg::ADDR_IRQ_STATUS, 32'h3f);
      idle(3);
      check("irq cleared", 1'b0, IRQ);
    end
    bus(1'b1, otg_pkg::ADDR_IRQ_MASK, 32'h0);
    bus(1'b1, otg_pkg::ADDR_CTRL, 32'h40);
    idle(3);
    @(posedge CLK);
    CHIP_SELECT_N <= 1'b0;
    READ_STROBE_N <= 1'b0;
    idle(8);
    check("strobe wake", 1'b1, PLL_EN);
    @(posedge CLK);
    CHIP_SELECT_N <= 1'b1;
    READ_STROBE_N <= 1'b1;
    peer_rst <= 1'b1;
    @(posedge CLK);
    peer_rst <= 1'b0;
    src <= 3'h4;
    wait_bit(1, 1'b1);
    check("b pullup", 1'b1, n < 10);
    bus(1'b1, otg_pkg::ADDR_CTRL, 32'h06);
    wait_bit(1, 1'b0);
    check("b idle release", 1'b1, n <= 60);
    wait_bit(0, 1'b1);
    check("b settle", 1'b1, n >= 1200 && n < 1200 + otg_pkg::CYC_B_RESET);
    wait_bit(0, 1'b0);
    check("b host", 1'b1, HOST_ROLE);
    bus(1'b1, otg_pkg::ADDR_CTRL, 32'h32);
    idle(3);
    check("b done", 2'b10, {DP_PULLUP_EN, HOST_ROLE});
    @(posedge CLK);
    src <= 3'h0;
    role_a <= 1'b0;
    peer_rst <= 1'b1;
    idle(8);
    @(posedge CLK);
    peer_rst <= 1'b0;
    src <= 3'h2;
    bus(1'b1, otg_pkg::ADDR_CTRL, 32'h01);
    wait_bit(2, 1'b1);
    check("a supply", 1'b1, VBUS_DRIVE);
    bus(1'b1, otg_pkg::ADDR_CTRL, 32'h07);
    hnp_en <= 1'b1;
    wait_bit(1, 1'b1);
    check("a answers", 1'b1, n < otg_pkg::CYC_A_SE0_RESP);
    check("a periph", 1'b0, HOST_ROLE);
    wait_bit(1, 1'b0);
    check("a idle release", 1'b1, n >= 40);
    wait_bit(0, 1'b1);
    check("a settle", 1'b1, n >= 1200 && n < 50000);
    wait_bit(0, 1'b0);
    check("a host again", 1'b1, HOST_ROLE);
    bus(1'b1, otg_pkg::ADDR_CTRL, 32'h0f);
    peer_rst <= 1'b1;
    @(posedge CLK);
    peer_rst <= 1'b0;
    wait_bit(1, 1'b1);
    wait_bit(1, 1'b0);
    idle(2);
    check("a ends", 2'b00, {VBUS_DRIVE, HOST_ROLE});
    @(posedge CLK);
    src <= 3'h0;
    idle(8);
    report_and_stop();
  end
endmodule

`default_nettype wire
